// File: verilog/dbg_defines.vh
// Constants for the serial debug command decoder
`ifndef DBG_DEFINES_VH
`define DBG_DEFINES_VH

// ----------------------------------------------------------------------
// Serial responses (bit 16 is the status bit of the 17-bit word)
// ----------------------------------------------------------------------
`define RESP_NOT_READY  17'h10000
`define RESP_BUS_ERR    17'h10001
`define RESP_ILLEGAL    17'h1FFFF
`define RESP_COMPLETE   17'h0FFFF

// ----------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------
`define OP_CREAD        12'h218
`define OP_CWRITE       12'h208
`define OP_SREAD        12'h250
`define OP_SWRITE       12'h240
`define OP_MREAD        8'h19
`define OP_MWRITE       8'h18
`define OP_NULL         16'h0000
`define OP_RSTPER       16'h0800

// ----------------------------------------------------------------------
// Operand size codes
// ----------------------------------------------------------------------
`define SZ_BYTE         2'h0
`define SZ_WORD         2'h1
`define SZ_LONG         2'h2
`define SZ_RSVD         2'h3

// ----------------------------------------------------------------------
// System register select codes
// ----------------------------------------------------------------------
`define SYS_RPC         4'h0
`define SYS_PCC         4'h1
`define SYS_TMPA        4'h8
`define SYS_FAR         4'h9
`define SYS_VBR         4'hA
`define SYS_SWORD       4'hB
`define SYS_USP         4'hC
`define SYS_SSP         4'hD
`define SYS_SFC         4'hE
`define SYS_DFC         4'hF

// ----------------------------------------------------------------------
// Register file slots
// ----------------------------------------------------------------------
`define RF_USP          5'h0F
`define RF_SSP          5'h10
`define RF_PCC          5'h11
`define RF_TMPA         5'h12
`define RF_VBR          5'h13

// ----------------------------------------------------------------------
// Wishbone map, fields, reset values, timing
// ----------------------------------------------------------------------
`define WB_CTRL         8'h00
`define WB_STAT         8'h04
`define WB_SWORD        8'h08
`define WB_RPC          8'h0C
`define CTRL_EN         0
`define SWORD_SBIT      13
`define SWORD_RST       16'h2700
`define RSTPER_CYCLES   512

`endif

// File: verilog/dbg_reg_file.v
// Core register storage for the debug command decoder
`timescale 1ns/1ps

module dbg_reg_file #(
   parameter DW = 32,
   parameter AW = 5
) (
   // Clock
   input  wire          core_clk,
   // Write port
   input  wire          wrEn,
   input  wire [AW-1:0] wrAddr,
   input  wire [DW-1:0] wrData,
   // Read port, data one cycle later
   input  wire [AW-1:0] rdAddr,
   output reg  [DW-1:0] rdData_q
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // No reset: contents are software state, not control
   always @(posedge core_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData_q <= mem[rdAddr];
   end

endmodule

// File: verilog/debug_command_decoder.v
// Serial debug command decoder with core and system register access
`timescale 1ns/1ps
`include "dbg_defines.vh"

// Operation
// - size 00 byte, 01 word, 10 long
// - select bit one address, zero data register
// - address two words, data one or two
// - multi-word values go high word first
// - command and result traffic overlap per transfer
// - command slot returns previous low result
// - slot after command: not-ready, illegal, complete or read data
// - ready for next transfer within eight clocks
// - memory read starts after low address transfer
// - transfer during memory access gets not-ready
// - long read result in two transfers after access, word or byte in one
// - bus or address error returns error status
// - core read returns 32 bits, high first
// - core write replaces 32 bits, then complete
// - register seven follows supervisor bit at entry
// - system read returns 32 bits zero-extended
// - system select codes decode to named registers
// - system write is long, narrow uses low word
// - fault address writes are ignored
// - system write loads command-complete response
// - reset peripherals 512 cycles; null does nothing
// - status bit plus data encode responses
module debug_command_decoder (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst,
   // Serial debug link
   input  wire        dsclk,
   input  wire        dsi,
   output reg         dso_q,
   // Register bus
   input  wire        wbCyc,
   input  wire        wbStb,
   input  wire        wbWe,
   input  wire [7:0]  wbAdr,
   input  wire [3:0]  wbSel,
   input  wire [31:0] wbDatI,
   output reg  [31:0] wbDatO_q,
   output reg         wbAck_q,
   // Bus unit
   output reg         memReq_q,
   output reg         memWe_q,
   output reg  [1:0]  memSize_q,
   output reg  [2:0]  memSpace_q,
   output reg  [31:0] memAddr_q,
   output reg  [31:0] memWdata_q,
   input  wire        memDone,
   input  wire        memErr,
   input  wire [31:0] memRdata,
   // System side
   input  wire [31:0] faultAddr,
   output reg         sysRst_q
);

   // -------------------------------------------------------------------
   // States and command kinds
   // -------------------------------------------------------------------
   localparam [3:0] ST_CMD    = 4'h0;
   localparam [3:0] ST_EXT_HI = 4'h1;
   localparam [3:0] ST_EXT_LO = 4'h2;
   localparam [3:0] ST_DAT_HI = 4'h3;
   localparam [3:0] ST_DAT_LO = 4'h4;
   localparam [3:0] ST_FETCH  = 4'h5;
   localparam [3:0] ST_MEM    = 4'h6;
   localparam [3:0] ST_RES_LO = 4'h7;
   localparam [3:0] ST_RST    = 4'h8;

   localparam [3:0] K_ILL = 4'h0;
   localparam [3:0] K_NUL = 4'h1;
   localparam [3:0] K_RST = 4'h2;
   localparam [3:0] K_CRD = 4'h3;
   localparam [3:0] K_CWR = 4'h4;
   localparam [3:0] K_SRD = 4'h5;
   localparam [3:0] K_SWR = 4'h6;
   localparam [3:0] K_MRD = 4'h7;
   localparam [3:0] K_MWR = 4'h8;

   localparam [4:0] LAST_BIT = 5'h10;
   localparam integer RST_LOAD = `RSTPER_CYCLES - 1;

   // -------------------------------------------------------------------
   // Decode functions
   // -------------------------------------------------------------------
   function sysValid;
      input [3:0] sel;
      begin
         sysValid = (sel == `SYS_RPC) || (sel == `SYS_PCC) || sel[3];
      end
   endfunction

   function [3:0] decodeCmd;
      input [15:0] w;
      begin
         decodeCmd = K_ILL;
         if (w == `OP_NULL) begin
            decodeCmd = K_NUL;
         end else if (w == `OP_RSTPER) begin
            decodeCmd = K_RST;
         end else if (w[15:4] == `OP_CREAD) begin
            decodeCmd = K_CRD;
         end else if (w[15:4] == `OP_CWRITE) begin
            decodeCmd = K_CWR;
         end else if (w[15:4] == `OP_SREAD && sysValid(w[3:0])) begin
            decodeCmd = K_SRD;
         end else if (w[15:4] == `OP_SWRITE && sysValid(w[3:0])) begin
            decodeCmd = K_SWR;
         end else if (w[5:0] == 6'h00 && w[7:6] != `SZ_RSVD) begin
            // Reserved size falls through to illegal
            if (w[15:8] == `OP_MREAD) begin
               decodeCmd = K_MRD;
            end else if (w[15:8] == `OP_MWRITE) begin
               decodeCmd = K_MWR;
            end
         end
      end
   endfunction

   function [4:0] coreIdx;
      input       isAddr;
      input [2:0] num;
      input       supAtEntry;
      begin
         if (isAddr && num == 3'h7) begin
            coreIdx = supAtEntry ? `RF_SSP : `RF_USP;
         end else begin
            coreIdx = {1'b0, isAddr, num};
         end
      end
   endfunction

   function inRf;
      input [3:0] sel;
      begin
         inRf = (sel == `SYS_PCC) || (sel == `SYS_TMPA) ||
                (sel == `SYS_VBR) || (sel == `SYS_USP) ||
                (sel == `SYS_SSP);
      end
   endfunction

   function [4:0] sysIdx;
      input [3:0] sel;
      begin
         case (sel)
            `SYS_PCC: sysIdx = `RF_PCC;
            `SYS_VBR: sysIdx = `RF_VBR;
            `SYS_USP: sysIdx = `RF_USP;
            `SYS_SSP: sysIdx = `RF_SSP;
            default:  sysIdx = `RF_TMPA;
         endcase
      end
   endfunction

   function [31:0] mergeLanes;
      input [31:0] old;
      input [31:0] val;
      input [3:0]  sel;
      integer i;
      begin
         mergeLanes = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               mergeLanes[i*8 +: 8] = val[i*8 +: 8];
            end
         end
      end
   endfunction

   // -------------------------------------------------------------------
   // Link synchronisers
   // -------------------------------------------------------------------
   reg sclkS1_q, sclkS2_q, sclkS3_q;
   reg dsiS1_q, dsiS2_q;

   always @(posedge core_clk) begin
      if (rst) begin
         sclkS1_q <= 1'b1;
         sclkS2_q <= 1'b1;
         sclkS3_q <= 1'b1;
         dsiS1_q  <= 1'b0;
         dsiS2_q  <= 1'b0;
      end else begin
         sclkS1_q <= dsclk;
         sclkS2_q <= sclkS1_q;
         sclkS3_q <= sclkS2_q;
         dsiS1_q  <= dsi;
         dsiS2_q  <= dsiS1_q;
      end
   end

   wire sclkRise = sclkS2_q & ~sclkS3_q;

   // -------------------------------------------------------------------
   // Serial shifter
   // -------------------------------------------------------------------
   reg  [4:0]  rxCnt_q;
   reg  [16:0] rxShift_q;
   reg  [16:0] txShift_q;
   reg         rxDone_q;
   reg         dbgEn_q;
   reg         pendValid_q;
   reg  [16:0] pendWord_q;
   reg  [16:0] txNext;

   // A response waits for an idle link so no transfer is corrupted
   wire loadPend = dbgEn_q & ~sclkRise & pendValid_q & (rxCnt_q == 5'h00);

   always @* begin
      txNext = txShift_q;
      if (!dbgEn_q) begin
         txNext = `RESP_NOT_READY;
      end else if (sclkRise) begin
         if (rxCnt_q == LAST_BIT) begin
            txNext = `RESP_NOT_READY;
         end else begin
            txNext = {txShift_q[15:0], 1'b0};
         end
      end else if (loadPend) begin
         txNext = pendWord_q;
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         rxCnt_q   <= 5'h00;
         rxShift_q <= 17'h00000;
         txShift_q <= `RESP_NOT_READY;
         dso_q     <= 1'b1;
         rxDone_q  <= 1'b0;
      end else begin
         txShift_q <= txNext;
         dso_q     <= txNext[16];
         rxDone_q  <= 1'b0;
         if (!dbgEn_q) begin
            rxCnt_q <= 5'h00;
         end else if (sclkRise) begin
            rxShift_q <= {rxShift_q[15:0], dsiS2_q};
            if (rxCnt_q == LAST_BIT) begin
               rxCnt_q  <= 5'h00;
               rxDone_q <= 1'b1;
            end else begin
               rxCnt_q <= rxCnt_q + 5'h01;
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // Register storage
   // -------------------------------------------------------------------
   wire [15:0] rxWord = rxShift_q[15:0];
   reg         entryS_q;
   reg         rfWe_q;
   reg  [4:0]  rfWaddr_q;
   reg  [31:0] rfWdata_q;
   wire [31:0] rfRdata;
   wire [4:0]  rfRaddr = (rxWord[15:4] == `OP_CREAD) ?
                         coreIdx(rxWord[3], rxWord[2:0], entryS_q) :
                         sysIdx(rxWord[3:0]);

   dbg_reg_file #(
      .DW (32),
      .AW (5)
   ) regFile (
      .core_clk (core_clk),
      .wrEn     (rfWe_q),
      .wrAddr   (rfWaddr_q),
      .wrData   (rfWdata_q),
      .rdAddr   (rfRaddr),
      .rdData_q (rfRdata)
   );

   // -------------------------------------------------------------------
   // Command sequencer
   // -------------------------------------------------------------------
   reg  [3:0]  state_q;
   reg  [3:0]  kind_q;
   reg  [3:0]  sel_q;
   reg  [15:0] hiWord_q;
   reg  [15:0] resLo_q;
   reg  [31:0] rpc_q;
   reg  [15:0] sword_q;
   reg  [2:0]  sfc_q;
   reg  [2:0]  dfc_q;
   reg  [9:0]  rstCnt_q;
   reg  [31:0] fetchVal;

   wire [3:0]  kindNow = decodeCmd(rxWord);
   wire [31:0] extLong = {hiWord_q, rxWord};
   wire        wbHit   = wbCyc & wbStb & ~wbAck_q;
   wire [31:0] swordMrg = mergeLanes({16'h0000, sword_q}, wbDatI, wbSel);

   always @* begin
      case (sel_q)
         `SYS_RPC:   fetchVal = rpc_q;
         `SYS_FAR:   fetchVal = faultAddr;
         `SYS_SWORD: fetchVal = {16'h0000, sword_q};
         `SYS_SFC:   fetchVal = {29'h00000000, sfc_q};
         `SYS_DFC:   fetchVal = {29'h00000000, dfc_q};
         default:    fetchVal = rfRdata;
      endcase
      if (kind_q == K_CRD) begin
         fetchVal = rfRdata;
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         state_q     <= ST_CMD;
         kind_q      <= K_NUL;
         sel_q       <= 4'h0;
         hiWord_q    <= 16'h0000;
         resLo_q     <= 16'h0000;
         pendValid_q <= 1'b0;
         pendWord_q  <= `RESP_COMPLETE;
         rfWe_q      <= 1'b0;
         rfWaddr_q   <= 5'h00;
         rfWdata_q   <= 32'h00000000;
         rpc_q       <= 32'h00000000;
         sword_q     <= `SWORD_RST;
         sfc_q       <= 3'h0;
         dfc_q       <= 3'h0;
         entryS_q    <= 1'b0;
         dbgEn_q     <= 1'b0;
         rstCnt_q    <= 10'h000;
         sysRst_q    <= 1'b0;
         memReq_q    <= 1'b0;
         memWe_q     <= 1'b0;
         memSize_q   <= `SZ_BYTE;
         memSpace_q  <= 3'h0;
         memAddr_q   <= 32'h00000000;
         memWdata_q  <= 32'h00000000;
         wbAck_q     <= 1'b0;
         wbDatO_q    <= 32'h00000000;
      end else begin
         rfWe_q  <= 1'b0;
         wbAck_q <= wbHit;
         if (loadPend) begin
            pendValid_q <= 1'b0;
         end
         // Register bus, one-cycle answer
         if (wbHit && wbWe) begin
            case (wbAdr)
               `WB_CTRL: begin
                  if (wbSel[0]) begin
                     dbgEn_q <= wbDatI[`CTRL_EN];
                     if (wbDatI[`CTRL_EN] && !dbgEn_q) begin
                        entryS_q <= sword_q[`SWORD_SBIT];
                     end
                  end
               end
               `WB_SWORD: sword_q <= swordMrg[15:0];
               `WB_RPC:   rpc_q <= mergeLanes(rpc_q, wbDatI, wbSel);
               default: ;
            endcase
         end
         if (wbHit && !wbWe) begin
            case (wbAdr)
               `WB_CTRL:  wbDatO_q <= {31'h00000000, dbgEn_q};
               `WB_STAT:  wbDatO_q <= {24'h000000, sysRst_q, memReq_q,
                                       entryS_q, 1'b0, state_q};
               `WB_SWORD: wbDatO_q <= {16'h0000, sword_q};
               `WB_RPC:   wbDatO_q <= rpc_q;
               default:   wbDatO_q <= 32'h00000000;
            endcase
         end
         // Debug sequencer
         case (state_q)
            ST_CMD: begin
               if (rxDone_q) begin
                  kind_q <= kindNow;
                  sel_q  <= rxWord[3:0];
                  case (kindNow)
                     K_ILL: begin
                        pendValid_q <= 1'b1;
                        pendWord_q  <= `RESP_ILLEGAL;
                     end
                     K_NUL: begin
                        pendValid_q <= 1'b1;
                        pendWord_q  <= `RESP_COMPLETE;
                     end
                     K_RST: begin
                        sysRst_q <= 1'b1;
                        rstCnt_q <= RST_LOAD[9:0];
                        state_q  <= ST_RST;
                     end
                     K_CRD, K_SRD: state_q <= ST_FETCH;
                     default: begin
                        memSize_q <= rxWord[7:6];
                        state_q   <= ST_EXT_HI;
                     end
                  endcase
               end
            end
            ST_EXT_HI: begin
               if (rxDone_q) begin
                  hiWord_q <= rxWord;
                  state_q  <= ST_EXT_LO;
               end
            end
            ST_EXT_LO: begin
               if (rxDone_q) begin
                  state_q <= ST_CMD;
                  case (kind_q)
                     K_CWR: begin
                        rfWe_q      <= 1'b1;
                        rfWaddr_q   <= coreIdx(sel_q[3], sel_q[2:0],
                                               entryS_q);
                        rfWdata_q   <= extLong;
                        pendValid_q <= 1'b1;
                        pendWord_q  <= `RESP_COMPLETE;
                     end
                     K_SWR: begin
                        case (sel_q)
                           `SYS_FAR:   ;
                           `SYS_RPC:   rpc_q <= extLong;
                           `SYS_SWORD: sword_q <= rxWord;
                           `SYS_SFC:   sfc_q <= rxWord[2:0];
                           `SYS_DFC:   dfc_q <= rxWord[2:0];
                           default: begin
                              rfWe_q    <= inRf(sel_q);
                              rfWaddr_q <= sysIdx(sel_q);
                              rfWdata_q <= extLong;
                           end
                        endcase
                        pendValid_q <= 1'b1;
                        pendWord_q  <= `RESP_COMPLETE;
                     end
                     K_MRD: begin
                        memAddr_q  <= extLong;
                        memWe_q    <= 1'b0;
                        memSpace_q <= sfc_q;
                        memReq_q   <= 1'b1;
                        state_q    <= ST_MEM;
                     end
                     default: begin
                        memAddr_q <= extLong;
                        state_q   <= (memSize_q == `SZ_LONG) ?
                                     ST_DAT_HI : ST_DAT_LO;
                     end
                  endcase
               end
            end
            ST_DAT_HI: begin
               if (rxDone_q) begin
                  hiWord_q <= rxWord;
                  state_q  <= ST_DAT_LO;
               end
            end
            ST_DAT_LO: begin
               if (rxDone_q) begin
                  memWdata_q <= (memSize_q == `SZ_LONG) ? extLong :
                                {16'h0000, rxWord};
                  memWe_q    <= 1'b1;
                  memSpace_q <= dfc_q;
                  memReq_q   <= 1'b1;
                  state_q    <= ST_MEM;
               end
            end
            ST_MEM: begin
               // Response stays not-ready until the access ends
               if (memDone) begin
                  memReq_q    <= 1'b0;
                  pendValid_q <= 1'b1;
                  state_q     <= ST_CMD;
                  if (memErr) begin
                     pendWord_q <= `RESP_BUS_ERR;
                  end else if (memWe_q) begin
                     pendWord_q <= `RESP_COMPLETE;
                  end else if (memSize_q == `SZ_LONG) begin
                     pendWord_q <= {1'b0, memRdata[31:16]};
                     resLo_q    <= memRdata[15:0];
                     state_q    <= ST_RES_LO;
                  end else if (memSize_q == `SZ_WORD) begin
                     pendWord_q <= {1'b0, memRdata[15:0]};
                  end else begin
                     pendWord_q <= {9'h000, memRdata[7:0]};
                  end
               end
            end
            ST_FETCH: begin
               pendValid_q <= 1'b1;
               pendWord_q  <= {1'b0, fetchVal[31:16]};
               resLo_q     <= fetchVal[15:0];
               state_q     <= ST_RES_LO;
            end
            ST_RES_LO: begin
               if (rxDone_q) begin
                  pendValid_q <= 1'b1;
                  pendWord_q  <= {1'b0, resLo_q};
                  state_q     <= ST_CMD;
               end
            end
            ST_RST: begin
               if (rstCnt_q == 10'h000) begin
                  sysRst_q    <= 1'b0;
                  pendValid_q <= 1'b1;
                  pendWord_q  <= `RESP_COMPLETE;
                  state_q     <= ST_CMD;
               end else begin
                  rstCnt_q <= rstCnt_q - 10'h001;
               end
            end
            default: state_q <= ST_CMD;
         endcase
      end
   end

endmodule

// File: bench/dbg_host_model.sv
// Host side of the serial debug link
`timescale 1ns/1ps
module dbg_host_model (
   // Link
   output logic dsclk,
   output logic dsi,
   input  wire  dso
);
   initial begin
      dsclk = 1'b1;
      dsi   = 1'b0;
   end
   // Clock stands high between frames, so no stray edge reaches the core
   task automatic xfer(input [15:0] t, output [16:0] r);
      // Calls start on a clock edge, so pins move by non-blocking assignment
      for (int i = 16; i >= 0; i--) begin
         dsclk <= 1'b0;
         dsi   <= (i == 16) ? 1'b0 : t[i];
         #40 r[i] = dso;
         dsclk <= 1'b1;
         #40;
      end
      dsi <= ~dsi;
      #120;
   endtask
endmodule

// File: bench/debug_command_decoder_assertions.sv
// Port checker for the debug command decoder
`timescale 1ns/1ps
module debug_command_decoder_assertions (
   // Clock and reset
   input wire        core_clk,
   input wire        rst,
   // Watched ports
   input wire        dso_q,
   input wire        wbCyc,
   input wire        wbStb,
   input wire        wbAck_q,
   input wire        memReq_q,
   input wire        memDone,
   input wire        memErr,
   input wire [31:0] memAddr_q,
   input wire        sysRst_q
);
   logic [9:0] hiCnt_q;
   always @(posedge core_clk)
      hiCnt_q <= sysRst_q ? hiCnt_q + 10'h001 : 10'h000;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_reset_idle:
   assert property ($fell(rst) |-> dso_q && !memReq_q && !sysRst_q)
      else $error("bad state after reset");
   a_ack_pulse:
   assert property (wbCyc && wbStb && !wbAck_q |=> wbAck_q ##1 !wbAck_q)
      else $error("ack not one pulse");
   a_req_holds:
   assert property (memReq_q && !memDone |=> memReq_q && $stable(memAddr_q))
      else $error("access request dropped");
   a_req_ends:
   assert property (memReq_q && memDone |=> !memReq_q)
      else $error("access request not ended");
   a_busy_status:
   assert property ($rose(memReq_q) |-> dso_q)
      else $error("busy link not at not-ready");
   a_data_status:
   assert property (memReq_q && memDone && !memErr |-> ##[1:8] !dso_q)
      else $error("no valid status after access");
   a_err_status:
   assert property (memReq_q && memDone && memErr |=> dso_q[*4])
      else $error("error status missing");
   a_reset_len:
   assert property ($fell(sysRst_q) |-> hiCnt_q == 10'h200)
      else $error("system reset length wrong");
   c_mem_ok: cover property (memDone && !memErr);
   c_mem_err: cover property (memDone && memErr);
   c_sys_rst: cover property ($fell(sysRst_q));
endmodule
bind debug_command_decoder debug_command_decoder_assertions chk (
   .core_clk(core_clk), .rst(rst), .dso_q(dso_q), .wbCyc(wbCyc),
   .wbStb(wbStb), .wbAck_q(wbAck_q), .memReq_q(memReq_q),
   .memDone(memDone), .memErr(memErr), .memAddr_q(memAddr_q),
   .sysRst_q(sysRst_q));

// File: bench/debug_command_decoder_bench.sv
// Self-checking bench for the debug command decoder
`timescale 1ns/1ps
`include "dbg_defines.vh"
module debug_command_decoder_bench;
   logic        core_clk, rst, wbCyc, wbStb, wbWe, memDone, memErr;
   logic [7:0]  wbAdr;
   logic [31:0] wbDatI, memRdata, faultAddr, rd;
   logic [16:0] rx;
   wire         dsclk, dsi, dso, wbAck, memReq, memWe, sysRst;
   wire  [1:0]  memSize;
   wire  [2:0]  memSpace;
   wire  [31:0] wbDatO, memAddr, memWdata;
   int          err_count, cmp_count, hiCnt, n;
   debug_command_decoder dut (
      .core_clk(core_clk), .rst(rst), .dsclk(dsclk), .dsi(dsi),
      .dso_q(dso), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(4'hF), .wbDatI(wbDatI), .wbDatO_q(wbDatO),
      .wbAck_q(wbAck), .memReq_q(memReq), .memWe_q(memWe),
      .memSize_q(memSize), .memSpace_q(memSpace), .memAddr_q(memAddr),
      .memWdata_q(memWdata), .memDone(memDone), .memErr(memErr),
      .memRdata(memRdata), .faultAddr(faultAddr), .sysRst_q(sysRst));
   dbg_host_model host (.dsclk(dsclk), .dsi(dsi), .dso(dso));
   always @(posedge core_clk)
      if (sysRst === 1'b1) hiCnt <= hiCnt + 1;
   task chk(input [31:0] got, input [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task stop_test;
      if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task tmo(input ok);
      if (!ok) begin
         err_count++;
         stop_test;
      end
   endtask
   // ---------------------------------------
   // Bus, link and memory helpers
   // ---------------------------------------
   task wb(input w, input [7:0] a, input [31:0] d);
      @(posedge core_clk);
      {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'h3, w, a, d};
      for (n = 0; n < 9 && wbAck !== 1'b1; n++) @(posedge core_clk);
      tmo(wbAck === 1'b1);
      rd = wbDatO;
      {wbCyc, wbStb} <= 2'h0;
   endtask
   task x(input [15:0] t, input [16:0] e);
      host.xfer(t, rx);
      chk({15'h0, rx}, {15'h0, e});
   endtask
   task wreq;
      for (n = 0; n < 99 && memReq !== 1'b1; n++) @(posedge core_clk);
      tmo(memReq === 1'b1);
   endtask
   task done(input e, input [31:0] d);
      @(posedge core_clk);
      {memDone, memErr, memRdata} <= {1'h1, e, d};
      @(posedge core_clk);
      memDone <= 1'b0;
   endtask
   // Core and system registers, illegal and reserved commands
   task t_regs;
      wb(1'b0, `WB_SWORD, 32'h0);
      chk(rd, {16'h0, `SWORD_RST});
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, `WB_CTRL, 32'h1);
      host.xfer(16'h240D, rx);
      x(16'h00AB, `RESP_NOT_READY);
      host.xfer(16'hCDEF, rx);
      x(16'h2409, `RESP_COMPLETE);
      host.xfer(16'h1111, rx);
      host.xfer(16'h2222, rx);
      x(16'h2509, `RESP_COMPLETE);
      x(`OP_NULL, 17'h0CAFE);
      x(16'h218F, 17'h00009);
      x(`OP_NULL, 17'h000AB);
      x(16'h250B, 17'h0CDEF);
      x(`OP_NULL, 17'h00000);
      x(16'h2083, 17'h02700);
      x(16'h1234, `RESP_NOT_READY);
      host.xfer(16'h5678, rx);
      x(16'h2183, `RESP_COMPLETE);
      x(`OP_NULL, 17'h01234);
      x(16'h0C00, 17'h05678);
      x(16'h19C0, `RESP_ILLEGAL);
      x(`OP_NULL, `RESP_ILLEGAL);
   endtask
   // Memory reads and write, error and reset of peripherals
   task t_mem;
      x(16'h1980, `RESP_COMPLETE);
      x(16'h0001, `RESP_NOT_READY);
      x(16'h0020, `RESP_NOT_READY);
      wreq;
      chk(memAddr, 32'h00010020);
      chk({memWe, memSize}, {1'b0, `SZ_LONG});
      x(`OP_NULL, `RESP_NOT_READY);
      done(1'b0, 32'hA5A55A5A);
      x(`OP_NULL, 17'h0A5A5);
      x(16'h1940, 17'h05A5A);
      x(16'h0000, `RESP_NOT_READY);
      x(16'h0030, `RESP_NOT_READY);
      wreq;
      chk({memWe, memSize}, {1'b0, `SZ_WORD});
      done(1'b1, 32'h0);
      x(`OP_RSTPER, `RESP_BUS_ERR);
      for (n = 0; n < 700 && (sysRst === 1'b1 || hiCnt == 0); n++)
         @(posedge core_clk);
      tmo(sysRst !== 1'b1 && hiCnt != 0);
      chk(hiCnt, `RSTPER_CYCLES);
      x(`OP_NULL, `RESP_COMPLETE);
      // Long memory write into the space set through the write space code
      x(16'h240F, `RESP_COMPLETE);
      x(16'h0000, `RESP_NOT_READY);
      x(16'h0005, `RESP_NOT_READY);
      x(16'h1880, `RESP_COMPLETE);
      x(16'h0004, `RESP_NOT_READY);
      x(16'h0100, `RESP_NOT_READY);
      x(16'h89AB, `RESP_NOT_READY);
      x(16'hCDEF, `RESP_NOT_READY);
      wreq;
      chk(memAddr, 32'h00040100);
      chk(memWdata, 32'h89ABCDEF);
      chk({memWe, memSpace}, {1'b1, 3'h5});
      done(1'b0, 32'h0);
      x(`OP_NULL, `RESP_COMPLETE);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      {rst, wbCyc, wbStb, wbWe, memDone, memErr} = 6'h20;
      {wbAdr, wbDatI, memRdata} = 72'h0;
      faultAddr = 32'hCAFE0009;
      hiCnt = 0;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk(dso, 1'b1);
      t_regs;
      t_mem;
      stop_test;
   end
endmodule
